// [hdl/stop_ctrl_defs.svh]
`ifndef STOP_CTRL_DEFS_SVH
`define STOP_CTRL_DEFS_SVH
// Register byte addresses on the bus
`define SC_ADR_CTRL       8'h00
`define SC_ADR_STOP       8'h04
`define SC_ADR_CUTOFF     8'h08
`define SC_ADR_STARTF     8'h0C
`define SC_ADR_STATUS     8'h10
`define SC_ADR_FCLR       8'h14
// Field positions in the control word
`define SC_CTRL_DUTY_LSB  0
`define SC_CTRL_REGEN_LSB 8
`define SC_CTRL_TERM_LSB  16
// Reset values
`define SC_RST_DUTY       8'h00
`define SC_RST_REGEN      8'h00
`define SC_RST_TERM       8'h00
`define SC_RST_STOP       16'h270F
`define SC_RST_CUTOFF     16'h270F
`define SC_RST_STARTF     16'h0005
// Setting codes
`define SC_SET_OFF        16'h270F
`define SC_SET_RAMP_PAIR  16'h22B8
`define SC_SET_TMR_MAX    16'h0064
`define SC_SET_PAIR_LO    16'h03E8
`define SC_SET_PAIR_HI    16'h044C
`define SC_CUT_HYST       16'h0014
`define SC_TERM_POS       8'h07
`define SC_TERM_NEG       8'h6B
// Timing: clock period and ms tick length in ns, derived cycle count, then counts in ms
`define SC_CLK_NS         10
`define SC_MS_NS          1000000
`define SC_MS_CYC         (`SC_MS_NS / `SC_CLK_NS)
`define SC_MS_PER_S       16'h03E8
`define SC_BLINK_MS       16'h0032
`endif

// [hdl/stop_ctrl_pkg.sv]
package stop_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_STOP       = 3'b000,
    ST_RUN        = 3'b001,
    ST_DECEL      = 3'b010,
    ST_COAST_WAIT = 3'b011,
    ST_CUTOFF     = 3'b100
  } stop_state_t;

  // Operating conditions reported by the rest of the drive
  typedef struct packed {
    logic pid;
    logic jog;
    logic traverse;
    logic power_fail_stop;
    logic panel_stop;
    logic comm_error_stop;
    logic fieldbus_estop;
  } run_cond_t;

  // Sticky fault flags
  typedef struct packed {
    logic power_loss;
    logic undervoltage;
    logic option;
    logic regen_ov;
  } fault_t;
endpackage

// [hdl/motor_stop_control.sv]
// What this block does
// [R1] Brake alarm at 85% of duty setting
// [R2] Overvoltage fault at full duty setting
// [R3] Brake alarm alone keeps output running
// [R4] Alarm terminal code 7 active-high, 107 inverted
// [R5] AC mains in DC feeding: option fault
// [R6] DC feeding suppresses undervoltage, power-loss faults
// [R7] Setting 9999 or 8888: ramp to stop
// [R8] Setting 0-100: coast after that many seconds
// [R9] Setting 1000-1100: coast after setting-1000 seconds
// [R10] Stop setting chooses start input meaning
// [R11] Run flag drops when output shuts off
// [R12] Override stops ignore the stop setting
// [R13] Timed mode follows frequency command until shutoff
// [R14] Restart while coasting uses starting frequency
// [R15] Cutoff when command and output below setting
// [R16] Resume above cutoff plus 2 Hz
// [R17] Compare output frequency before slip compensation
// [R18] Cutoff enabled inhibits DC injection braking
// [R19] Cutoff off during PID, jog, power-fail, traverse
// [R20] Reverse decel still coasts when both low
// [R21] Fast blink of direction indicator in cutoff at zero command
// [R22] Duty is on-time ratio over fixed window
`timescale 1ns/1ns
`include "stop_ctrl_defs.svh"
module motor_stop_control #(
  parameter int MS_CYCLES  = `SC_MS_CYC,
  parameter int WINDOW_MS  = 1000
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [31:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output      logic [31:0]             wb_dat_o,
  output      logic                    wb_ack_o,
  input  wire logic                    forward_start_input_i,
  input  wire logic                    reverse_start_input_i,
  input  wire logic                    ac_mains_detect_i,
  input  wire logic                    brake_on_i,
  input  wire stop_ctrl_pkg::run_cond_t run_cond_i,
  input  wire logic                    dc_feed_active_i,
  input  wire logic                    undervoltage_detect_i,
  input  wire logic                    power_loss_detect_i,
  input  wire logic [15:0]             freq_cmd_i,
  input  wire logic [15:0]             out_freq_pre_slip_i,
  output      logic                    output_shutoff_o,
  output      logic                    run_o,
  output      logic                    reverse_o,
  output      logic                    decel_req_o,
  output      logic                    restart_o,
  output      logic [15:0]             restart_freq_o,
  output      logic                    dc_inject_inhibit_o,
  output      logic                    direction_indicator_o,
  output      logic                    brake_alarm_display_o,
  output      logic                    brake_duty_alarm_out_o,
  output      stop_ctrl_pkg::fault_t   fault_o
);
  localparam logic [31:0] MS_LAST  = 32'(MS_CYCLES - 1);
  localparam logic [15:0] WIN_LAST = 16'(WINDOW_MS - 1);

  // Settings and state
  logic [7:0]  duty_set_reg, regen_mode_reg, term_code_reg;
  logic [15:0] stop_set_reg, cutoff_reg, startf_reg;
  stop_ctrl_pkg::stop_state_t state_reg, state_next;
  stop_ctrl_pkg::fault_t      fault_reg;
  stop_ctrl_pkg::run_cond_t   cond_m_reg, cond_reg;
  logic [3:0]  pin_m_reg, pin_reg;
  logic        fwd_in, rev_in, mains_in, brake_in;
  logic [31:0] div_reg;
  logic        ms_tick;
  logic [15:0] win_reg, on_reg, last_on_reg, ms_reg, sec_reg, blink_reg;
  logic        alarm_reg, blink_ph_reg;

  // Start, mains and brake pins and run conditions pass two flip-flops before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_m_reg  <= 4'h0;
      pin_reg    <= 4'h0;
      cond_m_reg <= '0;
      cond_reg   <= '0;
    end else begin
      pin_m_reg  <= {forward_start_input_i, reverse_start_input_i, ac_mains_detect_i, brake_on_i};
      pin_reg    <= pin_m_reg;
      cond_m_reg <= run_cond_i;
      cond_reg   <= cond_m_reg;
    end
  end
  assign {fwd_in, rev_in, mains_in, brake_in} = pin_reg;

  // Wishbone slave: ack one cycle after the request; write at the acked edge
  logic        wb_req, wb_wr;
  logic [31:0] rd_word, wmask;
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read decode; unmapped addresses answer zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i[7:0] == `SC_ADR_CTRL) begin
      rd_word = {8'h00, term_code_reg, regen_mode_reg, duty_set_reg};
    end else if (wb_adr_i[7:0] == `SC_ADR_STOP) begin
      rd_word = {16'h0000, stop_set_reg};
    end else if (wb_adr_i[7:0] == `SC_ADR_CUTOFF) begin
      rd_word = {16'h0000, cutoff_reg};
    end else if (wb_adr_i[7:0] == `SC_ADR_STARTF) begin
      rd_word = {16'h0000, startf_reg};
    end else if (wb_adr_i[7:0] == `SC_ADR_STATUS) begin
      rd_word = {last_on_reg, 5'h00, state_reg, alarm_reg, run_o, output_shutoff_o,
                 1'b0, fault_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= rd_word;
    end
  end

  // Setting registers, byte lanes honoured
  logic [31:0] ctrl_w;
  assign ctrl_w = ({8'h00, term_code_reg, regen_mode_reg, duty_set_reg} & ~wmask)
                | (wb_dat_i & wmask);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      duty_set_reg   <= `SC_RST_DUTY;
      regen_mode_reg <= `SC_RST_REGEN;
      term_code_reg  <= `SC_RST_TERM;
      stop_set_reg   <= `SC_RST_STOP;
      cutoff_reg     <= `SC_RST_CUTOFF;
      startf_reg     <= `SC_RST_STARTF;
    end else if (wb_wr) begin
      if (wb_adr_i[7:0] == `SC_ADR_CTRL) begin
        duty_set_reg   <= ctrl_w[`SC_CTRL_DUTY_LSB +: 8];
        regen_mode_reg <= ctrl_w[`SC_CTRL_REGEN_LSB +: 8];
        term_code_reg  <= ctrl_w[`SC_CTRL_TERM_LSB +: 8];
      end else if (wb_adr_i[7:0] == `SC_ADR_STOP) begin
        stop_set_reg <= (stop_set_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i[7:0] == `SC_ADR_CUTOFF) begin
        cutoff_reg <= (cutoff_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i[7:0] == `SC_ADR_STARTF) begin
        startf_reg <= (startf_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
    end
  end

  // Millisecond enable from the system clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= (div_reg == MS_LAST) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    end
  end
  assign ms_tick = (div_reg == MS_LAST);

  // Brake duty: on-time counted in ms over a fixed window, in per-mille
  logic [15:0] thr_full, thr_alarm;
  assign thr_full  = 16'(duty_set_reg) * 16'h000A;
  assign thr_alarm = (16'(duty_set_reg) * 16'h0011) >> 1;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_reg     <= 16'h0000;
      on_reg      <= 16'h0000;
      last_on_reg <= 16'h0000;
    end else if (ms_tick) begin
      win_reg <= (win_reg == WIN_LAST) ? 16'h0000 : win_reg + 16'h0001;
      if (win_reg == WIN_LAST) begin // [R22]
        last_on_reg <= on_reg + {15'h0000, brake_in};
        on_reg      <= 16'h0000;
      end else begin
        on_reg <= on_reg + {15'h0000, brake_in};
      end
    end
  end

  // Alarm holds while the current or previous window is above 85 percent
  logic alarm_next;
  assign alarm_next = (duty_set_reg != 8'h00) &&
                      (on_reg >= thr_alarm || last_on_reg >= thr_alarm); // [R1]
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alarm_reg              <= 1'b0;
      brake_alarm_display_o  <= 1'b0;
      brake_duty_alarm_out_o <= 1'b0;
    end else begin
      alarm_reg             <= alarm_next;
      brake_alarm_display_o <= alarm_next; // [R1]
      if (term_code_reg == `SC_TERM_POS) begin
        brake_duty_alarm_out_o <= alarm_reg; // [R4]
      end else if (term_code_reg == `SC_TERM_NEG) begin
        brake_duty_alarm_out_o <= !alarm_reg; // [R4]
      end else begin
        brake_duty_alarm_out_o <= 1'b0;
      end
    end
  end

  // Faults are sticky; a new event wins over a software clear
  logic dc_mode_a, dc_mode_b, fclr;
  logic [3:0] fset;
  assign dc_mode_a = regen_mode_reg == 8'h02 || regen_mode_reg == 8'h0A ||
                     regen_mode_reg == 8'h0B;
  assign dc_mode_b = dc_mode_a || regen_mode_reg == 8'h14 || regen_mode_reg == 8'h15;
  assign fclr = wb_wr && wb_adr_i[7:0] == `SC_ADR_FCLR;
  assign fset[0] = duty_set_reg != 8'h00 && on_reg >= thr_full; // [R2]
  assign fset[1] = dc_mode_a && dc_feed_active_i && mains_in; // [R5]
  assign fset[2] = undervoltage_detect_i && !(dc_mode_b && dc_feed_active_i); // [R6]
  assign fset[3] = power_loss_detect_i && !(dc_mode_b && dc_feed_active_i); // [R6]
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fset | (fault_reg & ~(fclr ? wb_dat_i[3:0] : 4'h0));
    end
  end
  assign fault_o = fault_reg;

  // Stop setting decode and start input meaning
  logic ramp_mode, pair_mode, tmr_a, tmr_b, start_in, dir_rev, override, cut_en;
  logic cmd_low, out_low, cmd_high, fault_any, coast_done;
  logic [15:0] coast_secs, cut_hi;
  assign tmr_a     = stop_set_reg <= `SC_SET_TMR_MAX;
  assign tmr_b     = stop_set_reg >= `SC_SET_PAIR_LO && stop_set_reg <= `SC_SET_PAIR_HI;
  assign ramp_mode = !(tmr_a || tmr_b); // [R7]
  assign pair_mode = stop_set_reg == `SC_SET_RAMP_PAIR || tmr_b; // [R10]
  assign start_in  = pair_mode ? fwd_in : (fwd_in || rev_in); // [R10]
  assign dir_rev   = pair_mode ? rev_in : (rev_in && !fwd_in); // [R10]
  assign coast_secs = tmr_b ? stop_set_reg - `SC_SET_PAIR_LO : stop_set_reg; // [R9]
  assign override  = cond_reg.power_fail_stop || cond_reg.panel_stop ||
                     cond_reg.comm_error_stop || cond_reg.fieldbus_estop;
  assign cut_en    = cutoff_reg != `SC_SET_OFF && !cond_reg.pid && !cond_reg.jog &&
                     !cond_reg.power_fail_stop && !cond_reg.traverse; // [R19]
  assign cmd_low   = freq_cmd_i <= cutoff_reg;
  assign out_low   = out_freq_pre_slip_i <= cutoff_reg; // [R17]
  assign cut_hi    = cutoff_reg + `SC_CUT_HYST;
  assign cmd_high  = freq_cmd_i > cut_hi; // [R16]
  assign fault_any = fault_reg.regen_ov || fault_reg.option ||
                     fault_reg.undervoltage || fault_reg.power_loss;
  assign coast_done = sec_reg >= coast_secs;

  // Stop sequencing; a fault shuts the output, the brake alarm does not
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stop_ctrl_pkg::ST_STOP: begin
        if (start_in && !fault_any) begin
          state_next = stop_ctrl_pkg::ST_RUN; // [R14]
        end
      end
      stop_ctrl_pkg::ST_RUN: begin
        if (cut_en && cmd_low && out_low) begin
          state_next = stop_ctrl_pkg::ST_CUTOFF; // [R15] [R20]
        end else if (!start_in) begin
          if (ramp_mode || override) begin
            state_next = stop_ctrl_pkg::ST_DECEL; // [R7] [R12]
          end else begin
            state_next = stop_ctrl_pkg::ST_COAST_WAIT; // [R8]
          end
        end
      end
      stop_ctrl_pkg::ST_DECEL: begin
        if (start_in && !override) begin
          state_next = stop_ctrl_pkg::ST_RUN;
        end else if (out_freq_pre_slip_i == 16'h0000 || (cut_en && cmd_low && out_low)) begin
          state_next = stop_ctrl_pkg::ST_STOP; // [R18]
        end
      end
      stop_ctrl_pkg::ST_COAST_WAIT: begin
        if (override) begin
          state_next = stop_ctrl_pkg::ST_DECEL; // [R12]
        end else if (start_in) begin
          state_next = stop_ctrl_pkg::ST_RUN;
        end else if (coast_done) begin
          state_next = stop_ctrl_pkg::ST_STOP; // [R8] [R9]
        end
      end
      stop_ctrl_pkg::ST_CUTOFF: begin
        if (!start_in) begin
          state_next = stop_ctrl_pkg::ST_STOP;
        end else if (cmd_high) begin
          state_next = stop_ctrl_pkg::ST_RUN; // [R16]
        end
      end
      default: begin
        state_next = stop_ctrl_pkg::ST_STOP;
      end
    endcase
    if (fault_any) begin
      state_next = stop_ctrl_pkg::ST_STOP; // [R2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= stop_ctrl_pkg::ST_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Coast delay timer, restarted on entry so the delay is whole seconds
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_reg != stop_ctrl_pkg::ST_COAST_WAIT) begin
      ms_reg  <= 16'h0000;
      sec_reg <= 16'h0000;
    end else if (ms_tick) begin
      if (ms_reg == `SC_MS_PER_S - 16'h0001) begin
        ms_reg  <= 16'h0000;
        sec_reg <= sec_reg + 16'h0001;
      end else begin
        ms_reg <= ms_reg + 16'h0001;
      end
    end
  end

  // Drive outputs; timed wait keeps following the command (no decel request)
  logic on_next;
  assign on_next = state_next == stop_ctrl_pkg::ST_RUN ||
                   state_next == stop_ctrl_pkg::ST_DECEL ||
                   state_next == stop_ctrl_pkg::ST_COAST_WAIT;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      output_shutoff_o    <= 1'b1;
      run_o               <= 1'b0;
      reverse_o           <= 1'b0;
      decel_req_o         <= 1'b0;
      restart_o           <= 1'b0;
      restart_freq_o      <= 16'h0000;
      dc_inject_inhibit_o <= 1'b0;
    end else begin
      output_shutoff_o    <= !on_next; // [R3]
      run_o               <= on_next; // [R11]
      decel_req_o         <= state_next == stop_ctrl_pkg::ST_DECEL; // [R13]
      restart_o           <= state_next == stop_ctrl_pkg::ST_RUN &&
                             (state_reg == stop_ctrl_pkg::ST_STOP ||
                              state_reg == stop_ctrl_pkg::ST_CUTOFF); // [R14] [R16]
      restart_freq_o      <= startf_reg;
      dc_inject_inhibit_o <= cutoff_reg != `SC_SET_OFF; // [R18]
      if (state_next == stop_ctrl_pkg::ST_RUN) begin
        reverse_o <= dir_rev;
      end
    end
  end

  // Direction lamp: steady while running, fast blink when held by cutoff with zero command
  logic hold_blink;
  assign hold_blink = state_reg == stop_ctrl_pkg::ST_CUTOFF && start_in &&
                      freq_cmd_i == 16'h0000;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blink_reg             <= 16'h0000;
      blink_ph_reg          <= 1'b0;
      direction_indicator_o <= 1'b0;
    end else begin
      if (ms_tick) begin
        blink_reg <= (blink_reg == `SC_BLINK_MS - 16'h0001) ? 16'h0000 : blink_reg + 16'h0001;
        if (blink_reg == `SC_BLINK_MS - 16'h0001) begin
          blink_ph_reg <= !blink_ph_reg;
        end
      end
      direction_indicator_o <= hold_blink ? blink_ph_reg : run_o; // [R21]
    end
  end

  // Checks
  property p_alarm_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (duty_set_reg != 8'h00 && on_reg >= thr_alarm) |=> alarm_reg;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm missed"); // [R1]
  property p_ov_fault;
    @(posedge clk_i) disable iff (!rst_n_i)
    (duty_set_reg != 8'h00 && on_reg >= thr_full) |=> fault_reg.regen_ov ##1 output_shutoff_o;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("overvoltage fault missed"); // [R2]
  property p_alarm_runs;
    @(posedge clk_i) disable iff (!rst_n_i)
    (alarm_reg && !fault_any && state_reg == stop_ctrl_pkg::ST_RUN) |-> !output_shutoff_o;
  endproperty
  a_alarm_runs: assert property (p_alarm_runs) else $error("alarm stopped output"); // [R3]
  property p_term_neg;
    @(posedge clk_i) disable iff (!rst_n_i)
    (term_code_reg == `SC_TERM_NEG && $stable(term_code_reg)) |-> 
      brake_duty_alarm_out_o == !$past(alarm_reg);
  endproperty
  a_term_neg: assert property (p_term_neg) else $error("inverted alarm wrong"); // [R4]
  property p_option;
    @(posedge clk_i) disable iff (!rst_n_i)
    (regen_mode_reg == 8'h0A && dc_feed_active_i && mains_in) |=> fault_reg.option;
  endproperty
  a_option: assert property (p_option) else $error("option fault missed"); // [R5]
  property p_uv_masked;
    @(posedge clk_i) disable iff (!rst_n_i)
    (dc_mode_b && dc_feed_active_i && !fault_reg.undervoltage) |=> !fault_reg.undervoltage;
  endproperty
  a_uv_masked: assert property (p_uv_masked) else $error("undervoltage not masked"); // [R6]
  property p_coast_end;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == stop_ctrl_pkg::ST_COAST_WAIT && coast_done && !start_in && !override)
      |=> output_shutoff_o && !run_o;
  endproperty
  a_coast_end: assert property (p_coast_end) else $error("coast shutoff late"); // [R8] [R11]
  property p_cutoff_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == stop_ctrl_pkg::ST_CUTOFF && start_in && cmd_high && !fault_any)
      |=> restart_o && run_o;
  endproperty
  a_cutoff_exit: assert property (p_cutoff_exit) else $error("cutoff restart missed"); // [R16]
  property p_cutoff_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == stop_ctrl_pkg::ST_CUTOFF && !cmd_high) |=> !run_o;
  endproperty
  a_cutoff_hold: assert property (p_cutoff_hold) else $error("cutoff released early"); // [R15]
  c_coast: cover property (@(posedge clk_i) state_reg == stop_ctrl_pkg::ST_COAST_WAIT
                           ##1 state_reg == stop_ctrl_pkg::ST_STOP);
  c_cutoff: cover property (@(posedge clk_i) state_reg == stop_ctrl_pkg::ST_CUTOFF
                            ##1 state_reg == stop_ctrl_pkg::ST_RUN);
  c_alarm: cover property (@(posedge clk_i) $rose(alarm_reg));
endmodule

// [bench/motor_load_model.sv]
`timescale 1ns/1ns
// Behavioural motor and power stage: reports output frequency
module motor_load_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        shutoff_i,
  input  wire logic        decel_i,
  input  wire logic [15:0] freq_cmd_i,
  output      logic [15:0] out_freq_o
);
  logic [15:0] target;

  // Ramp or follow the command; a shutoff drops frequency at once
  assign target = decel_i ? 16'h0000 : freq_cmd_i;

  // One step a cycle keeps ramps short but still observable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || shutoff_i) begin
      out_freq_o <= 16'h0000;
    end else if (out_freq_o < target) begin
      out_freq_o <= out_freq_o + 16'h0001;
    end else if (out_freq_o > target) begin
      out_freq_o <= out_freq_o - 16'h0001;
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
`include "stop_ctrl_defs.svh"
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fwd = 1'b0, rev = 1'b0;
  logic        mains = 1'b0, brake = 1'b0, dcf = 1'b0, uv = 1'b0, pl = 1'b0;
  logic        rs_seen = 1'b0;
  logic [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat, q;
  logic [15:0] cmd = 16'h0000, ofreq, rfreq;
  logic        ack, shut, run, revo, decel, rs, dci, dir, disp, alm;
  stop_ctrl_pkg::fault_t flt;
  stop_ctrl_pkg::run_cond_t cond = '0;
  logic [7:0]  ra[5] = '{`SC_ADR_CTRL, `SC_ADR_STOP, `SC_ADR_CUTOFF, `SC_ADR_STARTF, 8'h20};
  logic [31:0] rv[5] = '{32'h0000_0000, 32'h0000_270F, 32'h0000_270F, 32'h0000_0005,
                         32'h0000_0000};
  logic [7:0]  md[5] = '{8'h02, 8'h0A, 8'h0B, 8'h14, 8'h15};
  int          error_cnt = 0;
  int          checks_done = 0;

  // Short millisecond so timed coasting fits the run
  motor_stop_control #(.MS_CYCLES(10), .WINDOW_MS(1000)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .forward_start_input_i(fwd), .reverse_start_input_i(rev), .ac_mains_detect_i(mains),
    .brake_on_i(brake), .run_cond_i(cond), .dc_feed_active_i(dcf),
    .undervoltage_detect_i(uv), .power_loss_detect_i(pl), .freq_cmd_i(cmd),
    .out_freq_pre_slip_i(ofreq), .output_shutoff_o(shut), .run_o(run), .reverse_o(revo),
    .decel_req_o(decel), .restart_o(rs), .restart_freq_o(rfreq),
    .dc_inject_inhibit_o(dci), .direction_indicator_o(dir),
    .brake_alarm_display_o(disp), .brake_duty_alarm_out_o(alm), .fault_o(flt));

  motor_load_model u_motor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .shutoff_i(shut), .decel_i(decel),
    .freq_cmd_i(cmd), .out_freq_o(ofreq));

  // Clock and a sticky catch of the one-cycle restart pulse
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (rs === 1'b1) rs_seen <= 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single Wishbone cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h00_0000, a};
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the roughly 13k cycles the tests need
  initial begin
    tick(30000);
    error_cnt++;
    final_report();
  end

  // Test sequence
  initial begin
    tick(6);
    rst_n_i <= 1'b1;
    // Duty first: its window starts at reset release
    wb(1'b1, `SC_ADR_CTRL, 32'h0007_000A);
    fwd <= 1'b1;
    brake <= 1'b1;
    tick(870);
    chk(run, 1'b1);
    chk(alm, 1'b1);
    chk(flt.regen_ov, 1'b0);
    wb(1'b1, `SC_ADR_CTRL, 32'h006B_000A);
    tick(3);
    chk(alm, 1'b0);
    chk(disp, 1'b1);
    tick(250);
    chk(flt.regen_ov, 1'b1);
    fwd <= 1'b0;
    brake <= 1'b0;
    wb(1'b1, `SC_ADR_CTRL, 32'h0000_0000);
    wb(1'b1, `SC_ADR_FCLR, 32'h0000_000F);
    tick(3);
    chk({28'h000_0000, flt}, 32'h0000_0000);
    $display("duty test done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ra[i], 32'h0000_0000);
      chk(q, rv[i]);
    end
    $display("register test done");
    // Ramp stop, then start inputs read as direction pair
    cmd <= 16'h0032;
    fwd <= 1'b1;
    tick(8);
    chk(run, 1'b1);
    fwd <= 1'b0;
    tick(8);
    chk(decel, 1'b1);
    chk(shut, 1'b0);
    tick(80);
    wb(1'b1, `SC_ADR_STOP, 32'h0000_22B8);
    fwd <= 1'b1;
    rev <= 1'b1;
    tick(8);
    chk(revo, 1'b1);
    fwd <= 1'b0;
    tick(8);
    chk(decel, 1'b1);
    rev <= 1'b0;
    tick(80);
    $display("ramp test done");
    // Timed coast of 1001-1000 s; command keeps steering meanwhile
    wb(1'b1, `SC_ADR_STOP, 32'h0000_03E9);
    fwd <= 1'b1;
    tick(100);
    chk(revo, 1'b0);
    fwd <= 1'b0;
    cmd <= 16'h0050;
    tick(9000);
    chk(run, 1'b1);
    chk(ofreq, 16'h0050);
    tick(1100);
    chk(run, 1'b0);
    chk(shut, 1'b1);
    rs_seen <= 1'b0;
    fwd <= 1'b1;
    tick(8);
    chk(rs_seen, 1'b1);
    chk(rfreq, 16'h0005);
    wb(1'b1, `SC_ADR_STOP, 32'h0000_0000);
    fwd <= 1'b0;
    tick(8);
    chk(shut, 1'b1);
    // Panel stop overrides the zero-second coast and ramps instead
    cond.panel_stop <= 1'b1;
    fwd <= 1'b1;
    tick(8);
    fwd <= 1'b0;
    tick(6);
    chk(decel, 1'b1);
    cond <= '0;
    tick(20);
    $display("coast test done");
    // Cutoff at 10 Hz and 2 Hz hysteresis on resume
    wb(1'b1, `SC_ADR_STOP, 32'h0000_270F);
    wb(1'b1, `SC_ADR_CUTOFF, 32'h0000_0064);
    tick(2);
    chk(dci, 1'b1);
    cmd <= 16'h012C;
    fwd <= 1'b1;
    tick(320);
    chk(shut, 1'b0);
    cmd <= 16'h0050;
    tick(300);
    chk(shut, 1'b1);
    // Held by cutoff with start but no command: lamp toggles every 50 ms
    cmd <= 16'h0000;
    tick(5);
    q = {31'h0000_0000, dir};
    tick(500);
    chk(dir, !q[0]);
    cmd <= 16'h0078;
    tick(20);
    chk(shut, 1'b1);
    rs_seen <= 1'b0;
    cmd <= 16'h007D;
    tick(8);
    chk(shut, 1'b0);
    chk(rs_seen, 1'b1);
    fwd <= 1'b0;
    $display("cutoff test done");
    // Every feeding mode with mains present
    dcf <= 1'b1;
    uv <= 1'b1;
    pl <= 1'b1;
    mains <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, `SC_ADR_CTRL, {16'h0000, md[i], 8'h00});
      wb(1'b1, `SC_ADR_FCLR, 32'h0000_000F);
      tick(4);
      chk({28'h000_0000, flt}, {30'h0000_0000, i < 3, 1'b0});
    end
    $display("feeding test done");
    final_report();
  end
endmodule
